/* pkg/fspc_map.svh */
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH
// register byte addresses
`define FSPC_CTRL_OFS 32'h0000_0000
`define FSPC_KEY_OFS 32'h0000_0004
// control register field positions
`define FSPC_START_BIT 15
`define FSPC_PERMIT_BIT 14
`define FSPC_SEQERR_BIT 13
`define FSPC_ERASE_BIT 6
`define FSPC_OPC_LSB 0
`define FSPC_OPC_MSB 3
// reset value of control bits
`define FSPC_CTRL_RST 16'h0000
// unlock key values
`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'hAA
// nominal operation time and clock rate
`define FSPC_OP_TIME_NS 4000000
`define FSPC_CLK_PERIOD_NS 40
`define FSPC_OP_CYCLES (`FSPC_OP_TIME_NS / `FSPC_CLK_PERIOD_NS)
// flash geometry
`define FSPC_PAGE_BYTES 1536
`define FSPC_ROW_BYTES 192
`endif

/* pkg/fspc_pkg.sv */
package fspc_pkg;
    // sequencer states, gray along idle->busy->done
    typedef enum logic [1:0] {
        FSPC_IDLE = 2'b00,
        FSPC_BUSY = 2'b01,
        FSPC_DONE = 2'b11
    } fspc_state_t;
    // decoded flash action
    typedef enum logic [3:0] {
        FSPC_ACT_NONE = 4'h0,
        FSPC_ACT_BULK_ERASE = 4'h1,
        FSPC_ACT_GEN_SEG_ERASE = 4'h2,
        FSPC_ACT_SEC_SEG_ERASE = 4'h3,
        FSPC_ACT_PAGE_ERASE = 4'h4,
        FSPC_ACT_CFG_ERASE = 4'h5,
        FSPC_ACT_ROW_PROG = 4'h6,
        FSPC_ACT_WORD_PROG = 4'h7,
        FSPC_ACT_CFG_PROG = 4'h8,
        FSPC_ACT_UNIMPL = 4'hF
    } fspc_action_t;
    // unlock tracker
    typedef enum logic [1:0] {
        FSPC_KEY_NONE = 2'b00,
        FSPC_KEY_HALF = 2'b01,
        FSPC_KEY_OPEN = 2'b11
    } fspc_key_t;
endpackage

/* verilog/fspc_flash_ctrl.sv */
`timescale 1ns/1ps
`include "fspc_map.svh"
// Overview of operation
// - unlock needs 0x55 then 0xAA consecutive writes
// - key register write-only, reads zero
// - operation lasts nominally 4 ms, stall held
// - start bit set-only, hardware clears on completion
// - operations only allowed with write-permit set
// - sequence error flagged on improper sequence
// - erase flag selects erase versus program
// - erase-mode operation code decode
// - program-mode operation code decode
// - unlisted codes treated as unimplemented
// - control bits cleared by power-on reset, by software writes or by hardware
// - processor stalled for whole erase cycle
// - pages and rows aligned to geometry
module fspc_flash_ctrl
    import fspc_pkg::*;
#(
    parameter int unsigned OP_CYCLES = `FSPC_OP_CYCLES,
    parameter int unsigned CNT_W = 17
) (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic I_CLK_EN,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic O_CPU_STALL,
    output logic O_FLASH_GO,
    output logic [3:0] O_FLASH_ACTION
);
    logic wr_ph;
    logic rd_ph;
    logic [31:0] ph_addr;
    logic start;
    logic permit;
    logic seq_err;
    logic erase_sel;
    logic [3:0] opc;
    fspc_key_t key_st;
    fspc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic ctrl_wr;
    logic key_wr;
    logic start_req;
    logic start_ok;
    fspc_action_t act;

    // decode of operation code per erase flag, used by launch and output
    function automatic fspc_action_t decode_op(input logic er, input logic [3:0] code);
        fspc_action_t a;
        a = FSPC_ACT_UNIMPL;
        if (er) begin
            unique case (code)
                4'hF: a = FSPC_ACT_BULK_ERASE;
                4'hD: a = FSPC_ACT_GEN_SEG_ERASE;
                4'hC: a = FSPC_ACT_SEC_SEG_ERASE;
                4'h2: a = FSPC_ACT_PAGE_ERASE;
                4'h0: a = FSPC_ACT_CFG_ERASE;
                4'h3, 4'h1: a = FSPC_ACT_NONE;
                default: a = FSPC_ACT_UNIMPL;
            endcase
        end else begin
            unique case (code)
                4'h1: a = FSPC_ACT_ROW_PROG;
                4'h3: a = FSPC_ACT_WORD_PROG;
                4'h0: a = FSPC_ACT_CFG_PROG;
                4'hF, 4'hD, 4'hC, 4'h2: a = FSPC_ACT_NONE;
                default: a = FSPC_ACT_UNIMPL;
            endcase
        end
        return a;
    endfunction

    // address phase capture; accept transfers of any size when bus is ready
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            wr_ph <= 1'b0;
            rd_ph <= 1'b0;
            ph_addr <= 32'h0000_0000;
        end else if (I_CLK_EN && I_HREADY) begin
            wr_ph <= I_HSEL && I_HTRANS[1] && I_HWRITE;
            rd_ph <= I_HSEL && I_HTRANS[1] && !I_HWRITE;
            ph_addr <= I_HADDR;
        end
    end

    assign ctrl_wr = wr_ph && (ph_addr[7:0] == `FSPC_CTRL_OFS);
    assign key_wr = wr_ph && (ph_addr[7:0] == `FSPC_KEY_OFS);
    // start written while idle; writes during a run are swallowed by the stall
    assign start_req = ctrl_wr && I_HWDATA[`FSPC_START_BIT] && (state == FSPC_IDLE);
    assign start_ok = start_req && (key_st == FSPC_KEY_OPEN) && I_HWDATA[`FSPC_PERMIT_BIT];
    assign act = decode_op(I_HWDATA[`FSPC_ERASE_BIT], I_HWDATA[`FSPC_OPC_MSB:`FSPC_OPC_LSB]);

    // unlock tracker; any other register write breaks the pair
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            key_st <= FSPC_KEY_NONE;
        end else if (I_CLK_EN && wr_ph) begin
            if (key_wr && I_HWDATA[7:0] == `FSPC_KEY_FIRST) begin
                key_st <= FSPC_KEY_HALF;
            end else if (key_wr && key_st == FSPC_KEY_HALF
                         && I_HWDATA[7:0] == `FSPC_KEY_SECOND) begin
                key_st <= FSPC_KEY_OPEN;
            end else begin
                key_st <= FSPC_KEY_NONE;
            end
        end
    end

    // control fields; I_NRST stands for power-on reset only
    // cleared by power-on reset or by a control write while idle
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            permit <= 1'b0;
            erase_sel <= 1'b0;
            opc <= 4'h0;
        end else if (I_CLK_EN && ctrl_wr && state == FSPC_IDLE) begin
            permit <= I_HWDATA[`FSPC_PERMIT_BIT];
            // erase flag latched for readback only; launch decodes the written bit
            erase_sel <= I_HWDATA[`FSPC_ERASE_BIT];
            opc <= I_HWDATA[`FSPC_OPC_MSB:`FSPC_OPC_LSB];
        end
    end

    // start bit: set by software only, cleared by hardware at finish
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            start <= 1'b0;
        end else if (I_CLK_EN) begin
            if (start_ok) begin
                start <= 1'b1;
            end else if (state == FSPC_DONE) begin
                start <= 1'b0;
            end
        end
    end

    // sequence error: set on bad start, cleared by a clean launch or software 0
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            seq_err <= 1'b0;
        end else if (I_CLK_EN) begin
            if (start_req && !start_ok) begin
                seq_err <= 1'b1;
            end else if (start_ok) begin
                seq_err <= 1'b0;
            end else if (ctrl_wr && state == FSPC_IDLE) begin
                seq_err <= seq_err & I_HWDATA[`FSPC_SEQERR_BIT];
            end
        end
    end

    // sequencer and timer; no-op and unimplemented codes still run the timer
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state <= FSPC_IDLE;
            cnt <= '0;
        end else if (I_CLK_EN) begin
            unique case (state)
                FSPC_IDLE: begin
                    if (start_ok) begin
                        state <= FSPC_BUSY;
                        cnt <= CNT_W'(OP_CYCLES - 1);
                    end
                end
                FSPC_BUSY: begin
                    if (cnt == '0) begin
                        state <= FSPC_DONE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                FSPC_DONE: begin
                    state <= FSPC_IDLE;
                end
                default: begin
                    state <= FSPC_IDLE;
                end
            endcase
        end
    end

    // flash macro command: action held for the run, go pulses at launch
    // unimplemented codes never reach the macro
    // macro aligns page and row addresses
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_FLASH_GO <= 1'b0;
            O_FLASH_ACTION <= FSPC_ACT_NONE;
        end else if (I_CLK_EN) begin
            O_FLASH_GO <= start_ok && act != FSPC_ACT_NONE && act != FSPC_ACT_UNIMPL;
            if (start_ok) begin
                O_FLASH_ACTION <= (act == FSPC_ACT_UNIMPL) ? FSPC_ACT_NONE : act;
            end else if (state == FSPC_DONE) begin
                O_FLASH_ACTION <= FSPC_ACT_NONE;
            end
        end
    end

    // cpu stall and bus wait; stall drops with the start bit
    // stall spans the whole cycle
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_CPU_STALL <= 1'b0;
            O_HREADYOUT <= 1'b1;
        end else if (I_CLK_EN) begin
            if (start_ok) begin
                O_CPU_STALL <= 1'b1;
                O_HREADYOUT <= 1'b0;
            end else if (state == FSPC_DONE) begin
                O_CPU_STALL <= 1'b0;
                O_HREADYOUT <= 1'b1;
            end
        end
    end

    // read data registered one cycle early from the address phase
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_HRDATA <= 32'h0000_0000;
            O_HRESP <= 1'b0;
        end else if (I_CLK_EN) begin
            O_HRESP <= 1'b0;
            if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE
                && I_HADDR[7:0] == `FSPC_CTRL_OFS) begin
                O_HRDATA <= {16'h0000, start, permit, seq_err, 6'h00,
                             erase_sel, 2'h0, opc};
            end else begin
                O_HRDATA <= 32'h0000_0000;
            end
        end
    end
endmodule

/* testbench/fspc_flash_ctrl_properties.sv */
`timescale 1ns/1ps
module fspc_props
    import fspc_pkg::*;
#(
    parameter int unsigned OP_CYCLES = 8
) (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_CPU_STALL,
    input wire logic O_FLASH_GO,
    input wire logic [3:0] O_FLASH_ACTION
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    // accepted address phases
    sequence rd_key;
        I_HSEL && I_HTRANS[1] && !I_HWRITE && I_HREADY && I_HADDR[7:0] == 8'h04;
    endsequence
    sequence wr_ctrl;
        I_HSEL && I_HTRANS[1] && I_HWRITE && I_HREADY && I_HADDR[7:0] == 8'h00;
    endsequence
    chk_key_zero:
    assert property (rd_key |=> O_HRDATA == 32'h0) else $error("key read not zero");
    chk_stall_hold:
    assert property ($rose(O_CPU_STALL) |-> O_CPU_STALL[*8] ##[1:4] !O_CPU_STALL)
        else $error("stall length off");
    chk_go_pulse:
    assert property (O_FLASH_GO |=> !O_FLASH_GO) else $error("go longer than one cycle");
    chk_go_stalls:
    assert property (O_FLASH_GO |-> ##[0:1] O_CPU_STALL) else $error("go without stall");
    chk_go_real:
    assert property (O_FLASH_GO |-> ##[0:1] (O_FLASH_ACTION != FSPC_ACT_NONE
        && O_FLASH_ACTION != FSPC_ACT_UNIMPL)) else $error("go with no action");
    chk_go_permit:
    assert property (wr_ctrl ##1 !I_HWDATA[14] |=> !O_FLASH_GO)
        else $error("launch without permit");
    chk_no_relaunch:
    assert property ($past(O_CPU_STALL, 2) && $past(O_CPU_STALL) && O_CPU_STALL
        |-> !O_FLASH_GO) else $error("go while running");
    chk_ready_back:
    assert property ($fell(O_HREADYOUT) |-> ##[8:12] O_HREADYOUT)
        else $error("bus stall not released");
endmodule

/* testbench/fspc_flash_ctrl_test.sv */
`timescale 1ns/1ps
module fspc_flash_ctrl_test;
    import fspc_pkg::*;
    logic clk = 0, nrst = 0, sel = 0, wr = 0, rdy, resp, stall, go, rd_pend = 0, e;
    logic cen = 1;
    logic [31:0] addr = 0, wdata = 0, hrdata;
    logic [1:0] trans = 0;
    logic [3:0] act, o, x;
    logic [15:0] lf = 16'h1E30;
    logic [31:0] rq[$];
    logic [3:0] aq[$];
    int n_errors = 0, n_checks = 0;
    // short op time keeps each launch a few cycles
    fspc_flash_ctrl #(.OP_CYCLES(8)) i_dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CLK_EN(cen),
        .I_HSEL(sel), .I_HADDR(addr), .I_HTRANS(trans), .I_HWRITE(wr), .I_HSIZE(3'h2),
        .I_HWDATA(wdata), .I_HREADY(rdy), .O_HRDATA(hrdata), .O_HREADYOUT(rdy),
        .O_HRESP(resp), .O_CPU_STALL(stall), .O_FLASH_GO(go), .O_FLASH_ACTION(act));
    initial forever #20 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, s, x);
        end
    endtask
    // bounded wait, a stuck bus ends the run
    task automatic wait_rdy();
        int k = 0;
        @(posedge clk);
        while (!rdy) begin
            if (++k > 40) begin
                n_errors++;
                stop_test();
            end
            @(posedge clk);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        sel <= 1;
        addr <= {24'h0, a};
        wr <= w;
        trans <= 2'b10;
        wait_rdy();
        sel <= 0;
        trans <= 2'b00;
        wdata <= d;
        wait_rdy();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back(x);
        xfer(a, 0, 32'h0);
    endtask
    // pair and start back to back
    // page address kept outside the block
    task automatic launch(input logic [7:0] k1, input logic [7:0] k2, input logic [15:0] c);
        xfer(8'h04, 1, {24'h0, k1});
        xfer(8'h04, 1, {24'h0, k2});
        xfer(8'h00, 1, {16'h0, c});
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // action expected per code and mode, no-op codes give none
    function automatic logic [3:0] exp_act(input logic e, input logic [3:0] o);
        if (e) begin
            case (o)
                4'hF: return FSPC_ACT_BULK_ERASE;
                4'hD: return FSPC_ACT_GEN_SEG_ERASE;
                4'hC: return FSPC_ACT_SEC_SEG_ERASE;
                4'h2: return FSPC_ACT_PAGE_ERASE;
                4'h0: return FSPC_ACT_CFG_ERASE;
                default: return FSPC_ACT_NONE;
            endcase
        end
        case (o)
            4'h1: return FSPC_ACT_ROW_PROG;
            4'h3: return FSPC_ACT_WORD_PROG;
            4'h0: return FSPC_ACT_CFG_PROG;
            default: return FSPC_ACT_NONE;
        endcase
    endfunction
    // watcher: read data in data phase, action at each go pulse
    always @(posedge clk) begin
        if (rd_pend && rdy) chk(hrdata, rq.pop_front());
        if (rd_pend && rdy) chk({31'h0, resp}, 32'h0);
        if (go) chk({28'h0, act}, {28'h0, aq.pop_front()});
        if (rdy) rd_pend <= sel && trans[1] && !wr;
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        $display("test reset values done");
        // wrong first key, then permit clear, then a broken pair
        lf = lfsr(lf);
        launch((lf[7:0] == 8'h55) ? 8'h12 : lf[7:0], 8'hAA, 16'hC001);
        rd(8'h00, 32'h6001);
        launch(8'h55, 8'hAA, 16'h8001);
        rd(8'h00, 32'h2001);
        xfer(8'h04, 1, 32'h55);
        xfer(8'h08, 1, {16'h0, lf});
        launch(8'hAA, 8'hAA, 16'hC001);
        rd(8'h00, 32'h6001);
        $display("test refused starts done");
        // all 16 program codes, then all 16 erase codes, swept in turn
        for (int i = 0; i < 32; i++) begin
            e = i[4];
            o = i[3:0];
            x = exp_act(e, o);
            if (x != FSPC_ACT_NONE) aq.push_back(x);
            launch(8'h55, 8'hAA, {2'b11, 7'h0, e, 2'b00, o});
            rd(8'h00, {16'h0, 2'b01, 7'h0, e, 2'b00, o});
        end
        $display("test all codes done");
        // frozen clock enable: a control write is lost
        cen <= 0;
        xfer(8'h00, 1, 32'h0000);
        @(posedge clk);
        cen <= 1;
        rd(8'h00, 32'h404F);
        $display("test clock enable freeze done");
        // power-on reset in mid-operation clears everything
        aq.push_back(FSPC_ACT_ROW_PROG);
        launch(8'h55, 8'hAA, 16'hC001);
        repeat (3) @(posedge clk);
        nrst <= 0;
        @(posedge clk);
        nrst <= 1;
        rd(8'h00, 32'h0);
        chk(aq.size(), 32'h0);
        $display("test reset in operation done");
        stop_test();
    end
endmodule
bind fspc_flash_ctrl fspc_props #(.OP_CYCLES(OP_CYCLES)) i_chk (.I_CORE_CLK(I_CORE_CLK),
    .I_NRST(I_NRST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_CPU_STALL(O_CPU_STALL), .O_FLASH_GO(O_FLASH_GO),
    .O_FLASH_ACTION(O_FLASH_ACTION));
